/* File: scr_consts.svh */
// Offsets, field positions and reset values of the control registers
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH
`define SCR_OFS_DEVICE_IDENTITY   8'h00
`define SCR_OFS_SOFT_RESET        8'h01
`define SCR_OFS_GENERAL_CONFIG    8'h03
`define SCR_ID_ADDR_MSB           7
`define SCR_ID_ADDR_LSB           1
`define SCR_ID_SETTING_BIT        0
`define SCR_ID_SETTING_RESET      1'b0
`define SCR_RST_FULL_BIT          1
`define SCR_RST_CORE_BIT          0
`define SCR_GEN_RESET             8'hD2
`define SCR_GEN_CRC_BIT           7
`define SCR_GEN_AUTO_ACK_BIT      5
`define SCR_GEN_FILTER_BIT        4
`define SCR_GEN_PASS_BIT          3
`define SCR_GEN_PCLK_AUTO_BIT     1
`define SCR_GEN_RW_MASK           8'hBA
`define SCR_PORT1_ADDR_STEP       7'h01
`define SCR_BYTE_BITS             4'h8
`define SCR_READ_UNMAPPED         8'h00
`endif

/* File: scr_host.sv */
// Local I2C host model for the serial control bus
`timescale 1ns/1ps
`default_nettype none
module scr_host (
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic sda_m;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Pull-up: a released line reads high
  assign sda = sda_m & ~sda_oe;
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Phases of 4 clocks keep scl high and low long enough
  task automatic bitx(input logic b, output logic r);
    wt(1);
    sda_m <= b;
    wt(3);
    scl <= 1'b1;
    wt(2);
    r = sda;
    wt(2);
    scl <= 1'b0;
  endtask
  task automatic start();
    wt(1);
    sda_m <= 1'b1;
    wt(3);
    scl <= 1'b1;
    wt(4);
    sda_m <= 1'b0;
    wt(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    wt(1);
    sda_m <= 1'b0;
    wt(3);
    scl <= 1'b1;
    wt(4);
    sda_m <= 1'b1;
    wt(4);
  endtask
  task automatic xfer(input logic [7:0] b, input logic a,
                      output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bitx(b[i], q[i]);
    bitx(a, k);
  endtask
endmodule // scr_host
`default_nettype wire

/* File: scr_pkg.sv */
// Types shared by the serializer control register bank
package scr_pkg;
  typedef enum logic [2:0] {
    SCR_IDLE, SCR_ADDR, SCR_PTR, SCR_WDATA, SCR_ACK, SCR_RDATA, SCR_RACK
  } scr_state_e;

  typedef struct packed {
    logic       crc_check_enable;
    logic       filter_enable;
    logic       pclk_auto_switch;
    logic [1:0] remote_write_auto_ack;
    logic [1:0] remote_nack_block;
    logic [1:0] auto_ack_all_remote;
    logic [1:0] pass_through;
  } scr_cfg_s;

  typedef struct packed {
    logic data_valid_strobe;
    logic horizontal_sync;
    logic vertical_sync;
  } scr_sync_s;
endpackage

/* File: scr_regs.sv */
// Serializer control registers with their I2C serial control slave
`include "scr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module scr_regs
  import scr_pkg::*;
#(
  parameter int unsigned ADDR_W = 7
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [6:0]   address_strap_pin,
  input  wire logic         second_port_enable,
  input  wire logic         second_port_select,
  input  wire logic         forward_all_remote,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  input  wire scr_sync_s    sync_in,
  output scr_sync_s         sync_out,
  output scr_cfg_s          cfg,
  output logic [6:0]        port0_address,
  output logic [6:0]        port1_address,
  output logic              core_reset_pulse,
  output logic              restore_defaults_pulse
);
  if (ADDR_W != 7) begin : g_bad_width
    $error("scr_regs serves only seven-bit slave addresses");
  end
  // I2C engine state
  scr_state_e st_r, st_nxt, after_r, after_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt;
  logic       drv_r, drv_nxt;
  logic       scl_q_r, sda_q_r;
  logic       wr_en;
  logic [7:0] rdata;
  // Register state, index 1 is the second port's copy
  logic [6:0] id_addr_r [2];
  logic [6:0] id_addr_nxt [2];
  logic       id_set_r, id_set_nxt;
  logic       crc_r, crc_nxt, filt_r, filt_nxt, pclk_r, pclk_nxt;
  logic [1:0] ack_r, ack_nxt, pass_r, pass_nxt;
  logic       full_rst_r, full_rst_nxt, core_rst_r, core_rst_nxt;
  logic       strap_done_r, strap_done_nxt;
  logic [6:0] strap_r, strap_nxt;
  logic       psel;
  // Filter state
  scr_sync_s  prev_r, prev_nxt, out_r, out_nxt;
  logic scl_rise, scl_fall, start_c, stop_c, hit0, hit1;
  assign scl_rise = scl_in & ~scl_q_r;
  assign scl_fall = ~scl_in & scl_q_r;
  assign start_c  = scl_in & scl_q_r & sda_q_r & ~sda_in;
  assign stop_c   = scl_in & scl_q_r & ~sda_q_r & sda_in;
  assign hit0     = sh_r[7:1] == port0_address;
  assign hit1     = second_port_enable && (sh_r[7:1] == port1_address);
  assign psel     = second_port_select;
  // Address in use per port
  always_comb begin
    port0_address = id_set_r ? id_addr_r[0] : strap_r;
    port1_address = id_set_r ? id_addr_r[1]
                             : strap_r + `SCR_PORT1_ADDR_STEP;
  end
  // Read data, reserved bits as reset value
  always_comb begin
    case (ptr_r)
      `SCR_OFS_DEVICE_IDENTITY: rdata = {id_addr_r[psel], id_set_r};
      `SCR_OFS_SOFT_RESET:      rdata = 8'h00;
      `SCR_OFS_GENERAL_CONFIG: begin
        rdata = `SCR_GEN_RESET & ~`SCR_GEN_RW_MASK;
        rdata[`SCR_GEN_CRC_BIT]       = crc_r;
        rdata[`SCR_GEN_AUTO_ACK_BIT]  = ack_r[psel];
        rdata[`SCR_GEN_FILTER_BIT]    = filt_r;
        rdata[`SCR_GEN_PASS_BIT]      = pass_r[psel];
        rdata[`SCR_GEN_PCLK_AUTO_BIT] = pclk_r;
      end
      default:                  rdata = `SCR_READ_UNMAPPED;
    endcase
  end
  // Serial control slave; its own state survives soft resets so an
  // acknowledge in flight is not cut short
  always_comb begin
    st_nxt    = st_r;
    after_nxt = after_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    ptr_nxt   = ptr_r;
    drv_nxt   = drv_r;
    wr_en     = 1'b0;
    if (start_c) begin
      st_nxt  = SCR_ADDR;
      cnt_nxt = 4'h0;
      drv_nxt = 1'b0;
    end else if (stop_c) begin
      st_nxt  = SCR_IDLE;
      drv_nxt = 1'b0;
    end else begin
      case (st_r)
        SCR_ADDR, SCR_PTR, SCR_WDATA: begin
          if (scl_rise && cnt_r != `SCR_BYTE_BITS) begin
            sh_nxt  = {sh_r[6:0], sda_in};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == `SCR_BYTE_BITS) begin
            drv_nxt = 1'b1;
            st_nxt  = SCR_ACK;
            if (st_r == SCR_ADDR) begin
              after_nxt = sh_r[0] ? SCR_RDATA : SCR_PTR;
              if (!(hit0 || hit1)) begin
                drv_nxt = 1'b0;
                st_nxt  = SCR_IDLE;
              end
            end else if (st_r == SCR_PTR) begin
              ptr_nxt   = sh_r;
              after_nxt = SCR_WDATA;
            end else begin
              wr_en     = 1'b1;
              ptr_nxt   = ptr_r + 8'h01;
              after_nxt = SCR_WDATA;
            end
          end
        end
        SCR_ACK: begin
          if (scl_fall) begin
            cnt_nxt = 4'h0;
            drv_nxt = 1'b0;
            st_nxt  = after_r;
            if (after_r == SCR_RDATA) begin
              sh_nxt  = rdata;
              ptr_nxt = ptr_r + 8'h01;
              drv_nxt = ~rdata[7];
              cnt_nxt = 4'h1;
            end
          end
        end
        SCR_RDATA: begin
          if (scl_fall) begin
            if (cnt_r == `SCR_BYTE_BITS) begin
              drv_nxt = 1'b0;
              st_nxt  = SCR_RACK;
            end else begin
              sh_nxt  = {sh_r[6:0], 1'b0};
              drv_nxt = ~sh_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        SCR_RACK: begin
          if (scl_rise) begin
            after_nxt = SCR_RDATA;
            st_nxt    = sda_in ? SCR_IDLE : SCR_ACK;
          end
        end
        default: st_nxt = SCR_IDLE;
      endcase
    end
  end
  // Register bank
  always_comb begin
    id_addr_nxt    = id_addr_r;
    id_set_nxt     = id_set_r;
    crc_nxt        = crc_r;
    filt_nxt       = filt_r;
    pclk_nxt       = pclk_r;
    ack_nxt        = ack_r;
    pass_nxt       = pass_r;
    strap_nxt      = strap_r;
    strap_done_nxt = 1'b1;
    full_rst_nxt   = 1'b0;
    core_rst_nxt   = 1'b0;
    if (!strap_done_r) begin
      strap_nxt      = address_strap_pin;
      id_addr_nxt[0] = address_strap_pin;
      id_addr_nxt[1] = address_strap_pin + `SCR_PORT1_ADDR_STEP;
    end else if (full_rst_r) begin
      id_addr_nxt[0] = strap_r;
      id_addr_nxt[1] = strap_r + `SCR_PORT1_ADDR_STEP;
      id_set_nxt     = `SCR_ID_SETTING_RESET;
      crc_nxt        = 1'(`SCR_GEN_RESET >> `SCR_GEN_CRC_BIT);
      filt_nxt       = 1'(`SCR_GEN_RESET >> `SCR_GEN_FILTER_BIT);
      pclk_nxt       = 1'(`SCR_GEN_RESET >> `SCR_GEN_PCLK_AUTO_BIT);
      ack_nxt        = {2{1'(`SCR_GEN_RESET >> `SCR_GEN_AUTO_ACK_BIT)}};
      pass_nxt       = {2{1'(`SCR_GEN_RESET >> `SCR_GEN_PASS_BIT)}};
    end else if (core_rst_r) begin
      id_addr_nxt[0] = strap_r;
      id_addr_nxt[1] = strap_r + `SCR_PORT1_ADDR_STEP;
    end else if (wr_en) begin
      case (ptr_r)
        `SCR_OFS_DEVICE_IDENTITY: begin
          id_addr_nxt[psel] = sh_r[`SCR_ID_ADDR_MSB:`SCR_ID_ADDR_LSB];
          id_set_nxt        = sh_r[`SCR_ID_SETTING_BIT];
        end
        `SCR_OFS_SOFT_RESET: begin
          full_rst_nxt = sh_r[`SCR_RST_FULL_BIT];
          core_rst_nxt = sh_r[`SCR_RST_CORE_BIT];
        end
        `SCR_OFS_GENERAL_CONFIG: begin
          crc_nxt        = sh_r[`SCR_GEN_CRC_BIT];
          ack_nxt[psel]  = sh_r[`SCR_GEN_AUTO_ACK_BIT];
          filt_nxt       = sh_r[`SCR_GEN_FILTER_BIT];
          pass_nxt[psel] = sh_r[`SCR_GEN_PASS_BIT];
          pclk_nxt       = sh_r[`SCR_GEN_PCLK_AUTO_BIT];
        end
        default: ;
      endcase
    end
  end
  // Sync filter: a level passes only once seen on two samples in a row
  always_comb begin
    prev_nxt = sync_in;
    if (core_rst_r || full_rst_r) begin
      out_nxt = '0;
    end else if (!filt_r) begin
      out_nxt = sync_in;
    end else begin
      out_nxt = (sync_in & prev_r) | (out_r & (sync_in | prev_r));
    end
  end
  always_comb begin
    sync_out                  = out_r;
    sda_out                   = 1'b0;
    sda_oe                    = drv_r;
    core_reset_pulse          = core_rst_r | full_rst_r;
    restore_defaults_pulse    = core_rst_r | full_rst_r;
    cfg.crc_check_enable      = crc_r;
    cfg.filter_enable         = filt_r;
    cfg.pclk_auto_switch      = pclk_r;
    cfg.remote_write_auto_ack = ack_r;
    cfg.remote_nack_block     = ack_r;
    cfg.auto_ack_all_remote   = ack_r & {2{forward_all_remote}};
    cfg.pass_through          = pass_r;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r         <= SCR_IDLE;
      after_r      <= SCR_IDLE;
      cnt_r        <= 4'h0;
      sh_r         <= 8'h00;
      ptr_r        <= 8'h00;
      drv_r        <= 1'b0;
      scl_q_r      <= 1'b1;
      sda_q_r      <= 1'b1;
      id_addr_r    <= '{default: 7'h00};
      id_set_r     <= `SCR_ID_SETTING_RESET;
      crc_r        <= 1'(`SCR_GEN_RESET >> `SCR_GEN_CRC_BIT);
      filt_r       <= 1'(`SCR_GEN_RESET >> `SCR_GEN_FILTER_BIT);
      pclk_r       <= 1'(`SCR_GEN_RESET >> `SCR_GEN_PCLK_AUTO_BIT);
      ack_r        <= 2'h0;
      pass_r       <= 2'h0;
      full_rst_r   <= 1'b0;
      core_rst_r   <= 1'b0;
      strap_done_r <= 1'b0;
      strap_r      <= 7'h00;
      prev_r       <= '0;
      out_r        <= '0;
    end else begin
      st_r         <= st_nxt;
      after_r      <= after_nxt;
      cnt_r        <= cnt_nxt;
      sh_r         <= sh_nxt;
      ptr_r        <= ptr_nxt;
      drv_r        <= drv_nxt;
      scl_q_r      <= scl_in;
      sda_q_r      <= sda_in;
      id_addr_r    <= id_addr_nxt;
      id_set_r     <= id_set_nxt;
      crc_r        <= crc_nxt;
      filt_r       <= filt_nxt;
      pclk_r       <= pclk_nxt;
      ack_r        <= ack_nxt;
      pass_r       <= pass_nxt;
      full_rst_r   <= full_rst_nxt;
      core_rst_r   <= core_rst_nxt;
      strap_done_r <= strap_done_nxt;
      strap_r      <= strap_nxt;
      prev_r       <= prev_nxt;
      out_r        <= out_nxt;
    end
  end
endmodule // scr_regs
`default_nettype wire

/* File: scr_regs_monitor.sv */
// Port assertions for the serializer control register bank
`timescale 1ns/1ps
`default_nettype none
module scr_regs_monitor
  import scr_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [6:0] address_strap_pin,
  input wire logic       forward_all_remote,
  input wire logic       sda_out,
  input wire scr_sync_s  sync_in,
  input wire scr_sync_s  sync_out,
  input wire scr_cfg_s   cfg,
  input wire logic [6:0] port0_address,
  input wire logic [6:0] port1_address,
  input wire logic       core_reset_pulse,
  input wire logic       restore_defaults_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_cfg_reset_value: assert property ($fell(reset) |-> cfg == 11'h700)
    else $error("cfg wrong after reset");
  a_strap_address: assert property ($fell(reset) |=>
    port0_address == address_strap_pin &&
    port1_address == address_strap_pin + 7'h01)
    else $error("address not from strap");
  a_all_remote_gate: assert property (cfg.auto_ack_all_remote ==
    (cfg.remote_write_auto_ack & {2{forward_all_remote}}))
    else $error("forward-all gating wrong");
  a_nack_hidden: assert property (
    cfg.remote_nack_block == cfg.remote_write_auto_ack)
    else $error("nack block not tied to auto ack");
  a_pulse_single: assert property (core_reset_pulse |=> !core_reset_pulse)
    else $error("reset pulse too long");
  a_pulses_paired: assert property (
    core_reset_pulse == restore_defaults_pulse)
    else $error("restore pulse not with reset pulse");
  a_strap_reload: assert property (core_reset_pulse |-> ##[1:2]
    port0_address == address_strap_pin)
    else $error("strap not reloaded");
  // Only one output cycle checked: filter may be toggled right after
  a_filter_short: assert property (
    (cfg.filter_enable && !sync_in.vertical_sync) [*3] ##1
    (cfg.filter_enable && sync_in.vertical_sync) ##1
    !sync_in.vertical_sync |=> !sync_out.vertical_sync)
    else $error("short pulse passed filter");
  a_filter_pass: assert property (
    (sync_in.data_valid_strobe && !core_reset_pulse) [*5] |->
    sync_out.data_valid_strobe)
    else $error("long pulse blocked");
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("sda driven high");

  c_soft_reset: cover property (core_reset_pulse);
  c_all_remote: cover property (cfg.auto_ack_all_remote != 2'b00);
  c_filter_off: cover property (!cfg.filter_enable && sync_in.vertical_sync);
endmodule // scr_regs_monitor

bind scr_regs scr_regs_monitor i_scr_regs_monitor (
  .clk(clk), .reset(reset), .address_strap_pin(address_strap_pin),
  .forward_all_remote(forward_all_remote), .sda_out(sda_out),
  .sync_in(sync_in), .sync_out(sync_out), .cfg(cfg),
  .port0_address(port0_address), .port1_address(port1_address),
  .core_reset_pulse(core_reset_pulse),
  .restore_defaults_pulse(restore_defaults_pulse));
`default_nettype wire

/* File: serializer_control_registers_bench.sv */
// Self-checking bench for the serializer control registers
`timescale 1ns/1ps
`default_nettype none
module serializer_control_registers_bench import scr_pkg::*;;
  logic       clk, reset, pen, psel, fwd, scl, sda, sda_out, sda_oe, cp, rp;
  logic [6:0] strap, dev, a0, a1;
  logic [7:0] v, d;
  logic [1:0] am, pm;
  scr_sync_s  si, so;
  scr_cfg_s   cfg;
  int         err_count, samples_checked;

  scr_regs i_scr_regs (.clk(clk), .reset(reset), .address_strap_pin(strap),
    .second_port_enable(pen), .second_port_select(psel),
    .forward_all_remote(fwd), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .sync_in(si), .sync_out(so), .cfg(cfg),
    .port0_address(a0), .port1_address(a1), .core_reset_pulse(cp),
    .restore_defaults_pulse(rp));
  scr_host i_scr_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Slow random video strobes so both long and short pulses occur
  always @(posedge clk) if ($urandom % 3 == 0) si <= scr_sync_s'($urandom);

  function automatic logic [7:0] gx(input logic [7:0] b, input logic a, p);
    return {b[7], 1'b1, a, b[4], p, 1'b0, b[1], 1'b0};
  endfunction
  task automatic chk(input string n, input logic [10:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic by(input logic [7:0] b, input logic ex);
    logic [7:0] q;
    logic       k;
    i_scr_host.xfer(b, 1'b1, q, k);
    chk("ack", 11'(k), 11'(ex));
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] b);
    i_scr_host.start();
    by({dev, 1'b0}, 1'b0);
    by(o, 1'b0);
    by(b, 1'b0);
    i_scr_host.stop();
  endtask
  task automatic rd(input logic [7:0] o);
    logic k;
    i_scr_host.start();
    by({dev, 1'b0}, 1'b0);
    by(o, 1'b0);
    i_scr_host.start();
    by({dev, 1'b1}, 1'b0);
    i_scr_host.xfer(8'hFF, 1'b1, d, k);
    i_scr_host.stop();
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h4913));
    reset = 1'b1;
    strap = 7'h08 + 7'($urandom % 100);
    dev = strap;
    si = '0;
    pen = 1'b0;
    psel = 1'b0;
    fwd = 1'b0;
    am = 2'b00;
    pm = 2'b00;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    chk("cfg_rst", cfg, 11'h700);
    chk("addr1", 11'(a1), 11'(strap + 7'h01));
    rd(8'h00);
    chk("id", 11'(d), {3'h0, strap, 1'b0});
    rd(8'h02);
    chk("unmapped", 11'(d), 11'h000);
    repeat (6) begin
      v = 8'($urandom);
      psel <= 1'($urandom);
      fwd <= 1'($urandom);
      wr(8'h03, v);
      am[psel] = v[5];
      pm[psel] = v[3];
      rd(8'h03);
      chk("gen", 11'(d), 11'(gx(v, v[5], v[3])));
      chk("cfg", cfg, {v[7], v[4], v[1], am, am, am & {2{fwd}}, pm});
    end
    psel <= 1'b0;
    wr(8'h00, {strap ^ 7'h40, 1'b1});
    dev = strap ^ 7'h40;
    chk("addr0", 11'(a0), 11'(dev));
    rd(8'h00);
    chk("id_set", 11'(d), {3'h0, dev, 1'b1});
    wr(8'h01, 8'h01);
    dev = strap;
    chk("addr0_core", 11'(a0), 11'(strap));
    rd(8'h03);
    chk("gen_core", 11'(d), 11'(gx(v, am[0], pm[0])));
    wr(8'h01, 8'h02);
    chk("cfg_full", cfg, 11'h700);
    rd(8'h00);
    chk("id_full", 11'(d), {3'h0, strap, 1'b0});
    rd(8'h01);
    chk("rst_rd", 11'(d), 11'h000);
    dev = strap + 7'h05;
    i_scr_host.start();
    by({dev, 1'b0}, 1'b1);
    i_scr_host.stop();
    pen <= 1'b1;
    dev = strap + 7'h01;
    rd(8'h03);
    chk("port1", 11'(d), 11'h0D2);
    tally_and_finish();
  end
endmodule // serializer_control_registers_bench
`default_nettype wire
